/* bench/sbcwd_host_model.sv */
// Serial bus master standing in for the host microcontroller.
// Assumes 16-bit frames, rising-edge sampling, MSB first, 6 ns link clock.
`timescale 1ns/10ps
module sbcwd_host_model (
    output logic      spiClk,  // Toggles only inside a frame
    output logic      spiCs_n, // Frame select
    output logic      spiDin,  // Host to device data
    input  wire logic spiDout  // Device to host data
);
    initial begin
        spiClk  = 1'b0;
        spiCs_n = 1'b1;
        spiDin  = 1'b0;
    end
    // One whole frame: flag, address, data out; data byte captured back
    task xfer(input logic wr, input logic [6:0] adr, input logic [7:0] din,
              output logic [7:0] dout);
        logic [15:0] word;
        word = {wr, adr, din};
        dout = 8'h00;
        spiCs_n = 1'b0;
        #6;
        for (int i = 15; i >= 0; i--) begin
            spiDin = word[i];
            #3 spiClk = 1'b1;
            if (i < 8) dout = {dout[6:0], spiDout};
            #3 spiClk = 1'b0;
        end
        #3 spiCs_n = 1'b1;
        // Released line shows the inverse
        spiDin = ~spiDin;
    endtask : xfer
endmodule : sbcwd_host_model

/* bench/sbcwd_regs_monitor.sv */
// Concurrent checks on the top-level ports of the control bank.
// Assumes every watched event and output belongs to clk_sys.
`timescale 1ns/10ps
module sbcwd_regs_monitor (
    input wire logic                   clk_sys,
    input wire logic                   rst_n,
    input wire sbcwd_pkg::sbcwd_mode_t devMode,
    input wire logic                   softReset,
    input wire logic                   restartEnter,
    input wire logic [1:0]             restartXcvrMode,
    input wire logic                   failSafeEnter,
    input wire logic                   failureFlag,
    input wire logic                   timerAEvt,
    input wire logic                   timerBEvt,
    input wire logic                   extWakeEvt,
    input wire logic                   statusEvt,
    input wire logic                   intGlobal,
    input wire logic [2:0]             wdPeriodSel,
    input wire logic                   wdTypeWindow,
    input wire logic                   wdStartOnBusWake,
    input wire logic                   wdStopOffLow,
    input wire logic                   wdStopOffHigh,
    input wire logic [1:0]             xcvrMode,
    input wire logic                   peakThresholdHigh,
    input wire logic                   cyclicAWakeEn,
    input wire logic                   cyclicBWakeEn,
    input wire logic                   failureOutputs,
    input wire logic                   cyclicWake,
    input wire logic                   intReq,
    input wire logic                   extWakeArm
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Restart entry not overridden by a soft reset
    sequence s_restart;
        restartEnter && !softReset;
    endsequence
    // Fail-safe entry with nothing of higher priority
    sequence s_failsafe;
        failSafeEnter && !softReset && !restartEnter;
    endsequence
    chk_fo_flag_hold: assert property (failureFlag |=> failureOutputs)
        else $error("failure outputs off while failure flag set");
    chk_restart_fo_off: assert property (s_restart ##0 !failureFlag |=> !failureOutputs)
        else $error("failure outputs still on after restart");
    chk_restart_wd: assert property (s_restart |=> wdPeriodSel == 3'h4 && !wdStopOffLow)
        else $error("watchdog fields not forced on restart");
    chk_soft_reset_vals: assert property (softReset |=> wdPeriodSel == 3'h4
        && wdStartOnBusWake && !wdTypeWindow && xcvrMode == 2'h0 && !peakThresholdHigh)
        else $error("soft reset values wrong");
    chk_restart_xcvr: assert property (s_restart |=> xcvrMode == $past(restartXcvrMode))
        else $error("transceiver mode not loaded on restart");
    chk_restart_keep: assert property (s_restart |=> !wdStopOffHigh
        && cyclicAWakeEn == $past(cyclicAWakeEn) && cyclicBWakeEn == $past(cyclicBWakeEn)
        && peakThresholdHigh == $past(peakThresholdHigh))
        else $error("restart changed kept bits");
    chk_failsafe_arm: assert property (s_failsafe |=> xcvrMode == 2'h1 && extWakeArm)
        else $error("fail-safe did not arm wake sources");
    chk_peak_stop_hold: assert property (devMode == sbcwd_pkg::SBCWD_STOP && !softReset
        |=> $stable(peakThresholdHigh))
        else $error("peak select changed in stop mode");
    chk_timer_wake: assert property ((timerAEvt && cyclicAWakeEn)
        || (timerBEvt && cyclicBWakeEn) |=> cyclicWake)
        else $error("enabled timer gave no wake");
    chk_int_sources: assert property (extWakeEvt || (statusEvt && intGlobal) |=> intReq)
        else $error("interrupt missing");
endmodule : sbcwd_regs_monitor
bind sbcwd_regs_top sbcwd_regs_monitor i_mon (.*);

/* bench/sbcwd_regs_top_tb.sv */
// Self-checking bench for the control bank, host model on the link.
// Assumes writes land within 4 system cycles after the frame closes.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin nFail++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module sbcwd_regs_top_tb;
    // Access row: write flag, address, written data, expected read-back
    typedef struct {logic wr; logic [6:0] adr; logic [7:0] dat; logic [7:0] exp;} sbcwd_row_t;
    logic clk_sys = 1'b0, rst_n = 1'b0, spiClk, spiCs_n, spiDin, spiDout, spiDoutEn;
    sbcwd_pkg::sbcwd_mode_t devMode = sbcwd_pkg::SBCWD_NORMAL;
    logic softReset = 1'b0, restartEnter = 1'b0, failSafeEnter = 1'b0, failureFlag = 1'b0;
    logic [1:0] restartXcvrMode = 2'h0, hwXcvrMode = 2'h0, hwStopOffVal = 2'h0;
    logic hwXcvrWe = 1'b0, hwStopOffWe = 1'b0, hwPeriodWe = 1'b0, hwBusWakeWe = 1'b0;
    logic [2:0] hwPeriodVal = 3'h0, wdPeriodSel;
    logic hwBusWakeVal = 1'b0, hwFoEnClr = 1'b0, timerAEvt = 1'b0, timerBEvt = 1'b0;
    logic extWakeEvt = 1'b0, statusEvt = 1'b0, intGlobal = 1'b0;
    logic wdTypeWindow, wdStartOnBusWake, wdStopOffLow, wdStopOffHigh, peakThresholdHigh;
    logic [1:0] xcvrMode;
    logic cyclicAWakeEn, cyclicBWakeEn, failureOutputs, cyclicWake, intReq, spiFail, extWakeArm;
    int nFail = 0, checksDone = 0, nSpiFail = 0, nInt = 0, nWake = 0, nArm = 0;
    logic [7:0] rdv; // Last byte read back
    sbcwd_row_t rows [12] = '{
        '{1'b0, 7'h03, 8'h00, 8'h14}, '{1'b0, 7'h04, 8'h00, 8'h00},
        '{1'b0, 7'h05, 8'h00, 8'h00}, '{1'b0, 7'h06, 8'h00, 8'h00},
        '{1'b1, 7'h03, 8'h3c, 8'h34}, '{1'b1, 7'h03, 8'he8, 8'he0},
        '{1'b1, 7'h04, 8'hff, 8'h03}, '{1'b1, 7'h04, 8'h02, 8'h02},
        '{1'b1, 7'h05, 8'hff, 8'h20}, '{1'b1, 7'h06, 8'hff, 8'hc4},
        '{1'b1, 7'h07, 8'hff, 8'h00}, '{1'b1, 7'h02, 8'h20, 8'h20}};
    always #2.5 clk_sys = ~clk_sys;
    // Counts one-cycle pulses from the bank
    always @(posedge clk_sys) begin
        if (spiFail === 1'b1) nSpiFail++;
        if (intReq === 1'b1) nInt++;
        if (cyclicWake === 1'b1) nWake++;
        if (extWakeArm === 1'b1) nArm++;
    end
    sbcwd_host_model i_host (.*);
    sbcwd_regs_top i_dut (.*);
    // Waits n edges, then moves just past the last one
    task step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    // One frame, then a gap for the write and the snapshot refresh
    task acc(input logic wr, input logic [6:0] adr, input logic [7:0] dat);
        i_host.xfer(wr, adr, dat, rdv);
        step(8);
    endtask : acc
    task chkRd(input logic [6:0] adr, input logic [7:0] exp);
        acc(1'b0, adr, 8'h00);
        `CHK("register read-back", exp, rdv)
    endtask : chkRd
    // One event pulse: timer A, timer B, status, other wake
    task evt(input logic [3:0] v, input logic g);
        intGlobal = g;
        {timerAEvt, timerBEvt, statusEvt, extWakeEvt} = v;
        step(1);
        {timerAEvt, timerBEvt, statusEvt, extWakeEvt} = 4'h0;
        step(3);
    endtask : evt
    task stopTest;
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stopTest
    initial begin
        #50000;
        nFail++;
        stopTest();
    end
    initial begin
        step(8);
        rst_n = 1'b1;
        step(4);
        foreach (rows[i]) begin
            if (rows[i].wr) acc(1'b1, rows[i].adr, rows[i].dat);
            chkRd(rows[i].adr, rows[i].exp);
        end
        failureFlag = 1'b1;
        acc(1'b1, 7'h02, 8'h00);
        `CHK("failure outputs", 1'b1, failureOutputs)
        failureFlag = 1'b0;
        step(2);
        `CHK("failure outputs", 1'b0, failureOutputs)
        acc(1'b1, 7'h02, 8'h20);
        restartXcvrMode = 2'h2;
        restartEnter = 1'b1;
        step(1);
        restartEnter = 1'b0;
        step(2);
        `CHK("failure outputs", 1'b0, failureOutputs)
        chkRd(7'h02, 8'h00);
        chkRd(7'h03, 8'ha4);
        chkRd(7'h04, 8'h02);
        chkRd(7'h05, 8'h20);
        chkRd(7'h06, 8'hc0);
        failSafeEnter = 1'b1;
        step(1);
        failSafeEnter = 1'b0;
        chkRd(7'h04, 8'h01);
        `CHK("wake arming pulses", 1, nArm)
        acc(1'b1, 7'h02, 8'h20);
        {hwXcvrWe, hwStopOffWe, hwPeriodWe, hwBusWakeWe, hwFoEnClr} = 5'h1f;
        {hwXcvrMode, hwStopOffVal, hwPeriodVal, hwBusWakeVal} = 8'hf5;
        step(1);
        {hwXcvrWe, hwStopOffWe, hwPeriodWe, hwBusWakeWe, hwFoEnClr} = 5'h00;
        chkRd(7'h04, 8'h03);
        chkRd(7'h03, 8'hf2);
        chkRd(7'h06, 8'hc4);
        chkRd(7'h02, 8'h00);
        acc(1'b1, 7'h03, 8'h01);
        chkRd(7'h03, 8'hf2);
        `CHK("parity refusals", 1, nSpiFail)
        devMode = sbcwd_pkg::SBCWD_STOP;
        intGlobal = 1'b1;
        acc(1'b1, 7'h05, 8'h00);
        chkRd(7'h05, 8'h20);
        `CHK("serial error pulses", 1, nSpiFail)
        `CHK("interrupt pulses", 0, nInt)
        devMode = sbcwd_pkg::SBCWD_NORMAL;
        acc(1'b1, 7'h06, 8'h40);
        evt(4'h4, 1'b0);
        evt(4'h8, 1'b0);
        evt(4'h2, 1'b0);
        evt(4'h2, 1'b1);
        evt(4'h1, 1'b1);
        `CHK("timer wake pulses", 1, nWake)
        `CHK("interrupt pulses", 3, nInt)
        softReset = 1'b1;
        step(1);
        softReset = 1'b0;
        chkRd(7'h03, 8'h14);
        chkRd(7'h04, 8'h00);
        chkRd(7'h05, 8'h00);
        chkRd(7'h06, 8'h00);
        stopTest();
    end
endmodule : sbcwd_regs_top_tb

/* src/sbcwd_pkg.sv */
// Types shared by the control bank, its monitor and its bench.
// Assumes the device state machine reports its mode with this enum.
package sbcwd_pkg;
    // Operating mode of the device as seen by the bank
    typedef enum logic [1:0] {
        SBCWD_INIT,
        SBCWD_NORMAL,
        SBCWD_STOP,
        SBCWD_SLEEP
    } sbcwd_mode_t;
endpackage : sbcwd_pkg

/* src/sbcwd_regs.svh */
// Register map, field positions, reset and forced values of the control bank.
// Included by the control bank and its serial link; holds definitions only.
`ifndef SBCWD_REGS_SVH
`define SBCWD_REGS_SVH

// Register addresses, 7-bit as carried in the serial frame
`define SBCWD_OFS_HW     7'h02
`define SBCWD_OFS_WD     7'h03
`define SBCWD_OFS_BUS    7'h04
`define SBCWD_OFS_PEAK   7'h05
`define SBCWD_OFS_WAKE   7'h06

// Watchdog control fields
`define SBCWD_WD_PAR     7
`define SBCWD_WD_STOPLO  6
`define SBCWD_WD_TYPE    5
`define SBCWD_WD_BUSWK   4
// Software failure-output enable in the mode/supply register
`define SBCWD_HW_FOEN    5
// Peak threshold select
`define SBCWD_PEAK_BIT   5
// Internal wake control fields
`define SBCWD_WK_TB      7
`define SBCWD_WK_TA      6
`define SBCWD_WK_STOPHI  2

// Reset and forced values
`define SBCWD_WD_RST     8'h14
`define SBCWD_PERIOD_RST 3'h4
`define SBCWD_XCVR_RST   2'h0
`define SBCWD_XCVR_FS    2'h1

// Serial frame: write flag, address, data
`define SBCWD_FRAME_BITS 16
`define SBCWD_FRM_WR     15
`endif

/* src/sbcwd_regs_top.sv */
// Watchdog, transceiver, peak threshold and internal wake control bank.
// Assumes a host on the serial link and the device state machine on
// clk_sys; mode, event and hardware-update inputs share clk_sys.
//
// Behaviour
// - Failure keeps outputs on until flag clears
// - Restart clears software failure-output enable
// - Bit 6 low-half stop-mode watchdog off
// - Bit 5 selects window or time-out
// - Bit 4 starts watchdog after bus wake
// - Watchdog control resets to 0x14
// - Restart forces bits 6,3 low, period 100
// - Reserved bits always read zero
// - Bus control bits 1:0 transceiver mode
// - Bus control resets zero, restart mode given
// - Fail-safe arms transceiver wake and external wakes
// - Peak bit selects high or low threshold
// - Peak writes only in init or normal
// - Peak register restart keeps only bit 5
// - Internal wake layout, restart keeps timer enables
// - Timer enable makes cyclic timer wake source
// - Bit 2 high-half stop-mode watchdog off
// - All-status config widens interrupt sources
`timescale 1ns/10ps
`include "sbcwd_regs.svh"
module sbcwd_regs_top (
    input  wire logic                 clk_sys,         // System clock
    input  wire logic                 rst_n,           // Power-on reset
    input  wire logic                 spiClk,          // Link clock
    input  wire logic                 spiCs_n,         // Frame select
    input  wire logic                 spiDin,          // Serial in
    output logic                      spiDout,         // Serial out
    output logic                      spiDoutEn,       // Serial out enable
    input  wire sbcwd_pkg::sbcwd_mode_t devMode,       // Current mode
    input  wire logic                 softReset,       // Soft reset pulse
    input  wire logic                 restartEnter,    // Restart entry pulse
    input  wire logic [1:0]           restartXcvrMode, // Mode at restart
    input  wire logic                 failSafeEnter,   // Fail-safe entry pulse
    input  wire logic                 failureFlag,     // Failure flag level
    input  wire logic                 hwXcvrWe,        // Transceiver update
    input  wire logic [1:0]           hwXcvrMode,      // Updated mode
    input  wire logic                 hwStopOffWe,     // Stop-off update
    input  wire logic [1:0]           hwStopOffVal,    // {high, low}
    input  wire logic                 hwPeriodWe,      // Period update
    input  wire logic [2:0]           hwPeriodVal,     // Updated period
    input  wire logic                 hwBusWakeWe,     // Bus-wake start update
    input  wire logic                 hwBusWakeVal,    // Updated value
    input  wire logic                 hwFoEnClr,       // Hardware clear of enable
    input  wire logic                 timerAEvt,       // Cyclic timer A expiry
    input  wire logic                 timerBEvt,       // Cyclic timer B expiry
    input  wire logic                 extWakeEvt,      // Other wake source event
    input  wire logic                 statusEvt,       // Non-wake status event
    input  wire logic                 intGlobal,       // All-status config bit
    output logic [2:0]                wdPeriodSel,     // Period select field
    output logic                      wdTypeWindow,    // 1 window, 0 time-out
    output logic                      wdStartOnBusWake,// Start after bus wake
    output logic                      wdStopOffLow,    // Stop-off bit 0
    output logic                      wdStopOffHigh,   // Stop-off bit 1
    output logic [1:0]                xcvrMode,        // Transceiver mode
    output logic                      peakThresholdHigh,// Peak select
    output logic                      cyclicAWakeEn,   // Timer A wake enable
    output logic                      cyclicBWakeEn,   // Timer B wake enable
    output logic                      failureOutputs,  // Failure outputs on
    output logic                      cyclicWake,      // Timer wake pulse
    output logic                      intReq,          // Interrupt pulse
    output logic                      spiFail,         // Rejected write pulse
    output logic                      extWakeArm       // Load 0x07 wake arming
);
    logic [15:0] frameWord;   // Frame from the link domain
    logic        frameToggle; // Link-domain frame event
    logic        togSync1;    // Toggle synchroniser first stage
    logic        togSync2;    // Toggle synchroniser second stage
    logic        togSeen;     // Last toggle level handled
    logic        csSync1;     // Select synchroniser first stage
    logic        csSync2;     // Select level in system domain
    logic [39:0] readBank;    // Snapshot seen by the link
    logic [39:0] next_readBank;
    logic        frameNew;    // One cycle per completed frame
    logic        hostWr;      // Frame is a write
    logic [6:0]  hostAddr;    // Frame address
    logic [7:0]  hostData;    // Frame data

    // Control state and next values
    logic [7:0]  wdCtrl;
    logic [1:0]  busMode;
    logic        peakSel;
    logic        wakeA;
    logic        wakeB;
    logic        stopHi;
    logic        swFoEn;
    logic [7:0]  next_wdCtrl;
    logic [1:0]  next_busMode;
    logic        next_peakSel;
    logic        next_wakeA;
    logic        next_wakeB;
    logic        next_stopHi;
    logic        next_swFoEn;
    logic        next_spiFail;
    logic        next_extWakeArm;
    logic        next_cyclicWake;
    logic        next_intReq;
    logic        next_failOut;
    logic        peakWrOk;    // Peak bit writable in this mode

    // Serial link on its own clock
    sbcwd_spi_link uLink (
        .spiClk      (spiClk),
        .spiCs_n     (spiCs_n),
        .spiDin      (spiDin),
        .rst_n       (rst_n),
        .readBank    (readBank),
        .spiDout     (spiDout),
        .spiDoutEn   (spiDoutEn),
        .frameWord   (frameWord),
        .frameToggle (frameToggle)
    );

    // Synchronisers for the frame event and the select level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            togSync1 <= 1'b0;
            togSync2 <= 1'b0;
            togSeen  <= 1'b0;
            csSync1  <= 1'b1;
            csSync2  <= 1'b1;
        end else begin
            togSync1 <= frameToggle;
            togSync2 <= togSync1;
            togSeen  <= togSync2;
            csSync1  <= spiCs_n;
            csSync2  <= csSync1;
        end
    end

    // Frame word is stable for a whole frame after its toggle
    assign frameNew = togSync2 ^ togSeen;
    assign hostWr   = frameWord[`SBCWD_FRM_WR];
    assign hostAddr = frameWord[14:8];
    assign hostData = frameWord[7:0];
    assign peakWrOk = (devMode == sbcwd_pkg::SBCWD_INIT) ||
                      (devMode == sbcwd_pkg::SBCWD_NORMAL);

    // Register next values: host write, then hardware, then mode events
    always_comb begin
        next_wdCtrl     = wdCtrl;
        next_busMode    = busMode;
        next_peakSel    = peakSel;
        next_wakeA      = wakeA;
        next_wakeB      = wakeB;
        next_stopHi     = stopHi;
        next_swFoEn     = swFoEn;
        next_spiFail    = 1'b0;
        next_extWakeArm = 1'b0;
        if (frameNew && hostWr) begin
            case (hostAddr)
                `SBCWD_OFS_HW: begin
                    next_swFoEn = hostData[`SBCWD_HW_FOEN];
                end
                `SBCWD_OFS_WD: begin
                    // Odd parity write is refused and flagged
                    if (^hostData) begin
                        next_spiFail = 1'b1;
                    end else begin
                        next_wdCtrl = {hostData[7:4], 1'b0, hostData[2:0]};
                    end
                end
                `SBCWD_OFS_BUS: begin
                    next_busMode = hostData[1:0];
                end
                `SBCWD_OFS_PEAK: begin
                    // Silently dropped outside init and normal
                    if (peakWrOk) begin
                        next_peakSel = hostData[`SBCWD_PEAK_BIT];
                    end
                end
                `SBCWD_OFS_WAKE: begin
                    next_wakeB  = hostData[`SBCWD_WK_TB];
                    next_wakeA  = hostData[`SBCWD_WK_TA];
                    next_stopHi = hostData[`SBCWD_WK_STOPHI];
                end
                default: begin
                    next_spiFail = 1'b0;
                end
            endcase
        end
        // Hardware updates override a host write in the same cycle
        if (hwXcvrWe) begin
            next_busMode = hwXcvrMode;
        end
        if (hwStopOffWe) begin
            next_wdCtrl[`SBCWD_WD_STOPLO] = hwStopOffVal[0];
            next_stopHi = hwStopOffVal[1];
        end
        if (hwPeriodWe) begin
            next_wdCtrl[2:0] = hwPeriodVal;
        end
        if (hwBusWakeWe) begin
            next_wdCtrl[`SBCWD_WD_BUSWK] = hwBusWakeVal;
        end
        if (hwFoEnClr) begin
            next_swFoEn = 1'b0;
        end
        // Fail-safe arms the transceiver as a wake source
        if (failSafeEnter) begin
            next_busMode    = `SBCWD_XCVR_FS;
            next_extWakeArm = 1'b1;
        end
        // Restart forced values
        if (restartEnter) begin
            next_wdCtrl[`SBCWD_WD_STOPLO] = 1'b0;
            next_wdCtrl[3]   = 1'b0;
            next_wdCtrl[2:0] = `SBCWD_PERIOD_RST;
            next_busMode     = restartXcvrMode;
            next_stopHi      = 1'b0;
            next_swFoEn      = 1'b0;
        end
        // Soft reset restores power-on values
        if (softReset) begin
            next_wdCtrl  = `SBCWD_WD_RST;
            next_busMode = `SBCWD_XCVR_RST;
            next_peakSel = 1'b0;
            next_wakeA   = 1'b0;
            next_wakeB   = 1'b0;
            next_stopHi  = 1'b0;
            next_swFoEn  = 1'b0;
        end
    end

    // Register state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wdCtrl     <= `SBCWD_WD_RST;
            busMode    <= `SBCWD_XCVR_RST;
            peakSel    <= 1'b0;
            wakeA      <= 1'b0;
            wakeB      <= 1'b0;
            stopHi     <= 1'b0;
            swFoEn     <= 1'b0;
            spiFail    <= 1'b0;
            extWakeArm <= 1'b0;
        end else begin
            wdCtrl     <= next_wdCtrl;
            busMode    <= next_busMode;
            peakSel    <= next_peakSel;
            wakeA      <= next_wakeA;
            wakeB      <= next_wakeB;
            stopHi     <= next_stopHi;
            swFoEn     <= next_swFoEn;
            spiFail    <= next_spiFail;
            extWakeArm <= next_extWakeArm;
        end
    end

    // Read snapshot, frozen while a frame is in progress
    always_comb begin
        next_readBank = readBank;
        if (csSync2) begin
            next_readBank = {wakeB, wakeA, 3'h0, stopHi, 2'h0,
                             2'h0, peakSel, 5'h00,
                             6'h00, busMode,
                             wdCtrl,
                             2'h0, swFoEn, 5'h00};
        end
    end

    // Snapshot register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            readBank <= 40'h0000000000;
        end else begin
            readBank <= next_readBank;
        end
    end

    // Outputs derived from state and events
    always_comb begin
        next_failOut = next_swFoEn | failureFlag;
        next_cyclicWake = (timerAEvt & wakeA) | (timerBEvt & wakeB);
        next_intReq = next_cyclicWake | extWakeEvt |
                      (intGlobal & statusEvt);
    end

    // Output flip-flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            failureOutputs    <= 1'b0;
            cyclicWake        <= 1'b0;
            intReq            <= 1'b0;
            wdPeriodSel       <= `SBCWD_PERIOD_RST;
            wdTypeWindow      <= 1'b0;
            wdStartOnBusWake  <= 1'b1;
            wdStopOffLow      <= 1'b0;
            wdStopOffHigh     <= 1'b0;
            xcvrMode          <= `SBCWD_XCVR_RST;
            peakThresholdHigh <= 1'b0;
            cyclicAWakeEn     <= 1'b0;
            cyclicBWakeEn     <= 1'b0;
        end else begin
            failureOutputs    <= next_failOut;
            cyclicWake        <= next_cyclicWake;
            intReq            <= next_intReq;
            wdPeriodSel       <= next_wdCtrl[2:0];
            wdTypeWindow      <= next_wdCtrl[`SBCWD_WD_TYPE];
            wdStartOnBusWake  <= next_wdCtrl[`SBCWD_WD_BUSWK];
            wdStopOffLow      <= next_wdCtrl[`SBCWD_WD_STOPLO];
            wdStopOffHigh     <= next_stopHi;
            xcvrMode          <= next_busMode;
            peakThresholdHigh <= next_peakSel;
            cyclicAWakeEn     <= next_wakeA;
            cyclicBWakeEn     <= next_wakeB;
        end
    end
endmodule : sbcwd_regs_top

/* src/sbcwd_spi_link.sv */
// Serial slave front end, running on the link clock.
// Assumes mode 0 framing: data sampled on the rising edge, MSB first,
// 16 bits per frame, chip select low for the whole frame.
`timescale 1ns/10ps
`include "sbcwd_regs.svh"
module sbcwd_spi_link (
    input  wire logic        spiClk,      // Link clock
    input  wire logic        spiCs_n,     // Frame select, low in frame
    input  wire logic        spiDin,      // Serial data in
    input  wire logic        rst_n,       // System reset, async
    input  wire logic [39:0] readBank,    // Quasi-static read snapshot
    output logic             spiDout,     // Serial data out
    output logic             spiDoutEn,   // Drive enable of data out
    output logic [15:0]      frameWord,   // Last complete frame
    output logic             frameToggle  // Flips once per frame
);
    logic [4:0]  bitCount;      // Rising edges seen in frame
    logic [14:0] shiftIn;       // Bits received so far
    logic [4:0]  next_bitCount;
    logic [14:0] next_shiftIn;
    logic [15:0] next_frameWord;
    logic        next_frameToggle;
    logic [7:0]  outShift;      // Read data being sent
    logic [7:0]  next_outShift;
    logic        next_spiDout;
    logic [7:0]  selByte;       // Byte addressed by the frame

    // Shift counter and receiver
    always_comb begin
        next_shiftIn = {shiftIn[13:0], spiDin};
        next_bitCount = bitCount;
        if (bitCount != 5'h10) begin
            next_bitCount = bitCount + 5'h01;
        end
        next_frameWord = frameWord;
        next_frameToggle = frameToggle;
        // Sixteenth edge completes the frame
        if (bitCount == 5'h0f) begin
            next_frameWord = {shiftIn, spiDin};
            next_frameToggle = ~frameToggle;
        end
    end

    // Frame state is cleared whenever select goes high
    always_ff @(posedge spiClk or posedge spiCs_n) begin
        if (spiCs_n) begin
            bitCount <= 5'h00;
            shiftIn  <= 15'h0000;
        end else begin
            bitCount <= next_bitCount;
            shiftIn  <= next_shiftIn;
        end
    end

    // Handed frame survives select edges
    always_ff @(posedge spiClk or negedge rst_n) begin
        if (!rst_n) begin
            frameWord   <= 16'h0000;
            frameToggle <= 1'b0;
        end else begin
            frameWord   <= next_frameWord;
            frameToggle <= next_frameToggle;
        end
    end

    // Address decode of the snapshot; unmapped reads give zero
    always_comb begin
        case (shiftIn[6:0])
            `SBCWD_OFS_HW:   selByte = readBank[7:0];
            `SBCWD_OFS_WD:   selByte = readBank[15:8];
            `SBCWD_OFS_BUS:  selByte = readBank[23:16];
            `SBCWD_OFS_PEAK: selByte = readBank[31:24];
            `SBCWD_OFS_WAKE: selByte = readBank[39:32];
            default:         selByte = 8'h00;
        endcase
        next_outShift = {outShift[6:0], 1'b0};
        next_spiDout = outShift[7];
        if (bitCount == 5'h08) begin
            next_outShift = {selByte[6:0], 1'b0};
            next_spiDout = selByte[7];
        end else if (bitCount < 5'h08) begin
            next_spiDout = 1'b0;
        end
    end

    // Output changes on the falling edge, half a bit ahead of sampling
    always_ff @(negedge spiClk or posedge spiCs_n) begin
        if (spiCs_n) begin
            outShift  <= 8'h00;
            spiDout   <= 1'b0;
            spiDoutEn <= 1'b0;
        end else begin
            outShift  <= next_outShift;
            spiDout   <= next_spiDout;
            spiDoutEn <= 1'b1;
        end
    end
endmodule : sbcwd_spi_link
